// ==== logic/dfa_manager.sv ====
// Fault and alarm supervision for the drive: trips, acknowledge, restart, log.
// Assumes synchronous comparator inputs, debounced keys and a running clock.
`timescale 1ns/1ps
module dfa_manager
    import dfa_pkg::*;
#(
    parameter int HOLD_CYC = DFA_FACTORY_HOLD_CYC,
    parameter int BARS_CYC = DFA_BARS_CYC,
    parameter int FLASH_CYC = DFA_FLASH_CYC
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [15:0] motor_current_in,
    input wire logic [15:0] rated_current_in,
    input wire logic dc_over_limit_in,
    input wire logic dc_under_limit_in,
    input wire logic start_leak_in,
    input wire logic system_error_in,
    input wire logic signed [8:0] switch_temp_in,
    input wire logic live_zero_lost_in,
    input wire logic supply_lost_in,
    input wire logic start_cmd_in,
    input wire logic [3:0] auto_restart_parameter_in,
    input wire logic key_ok_in,
    input wire logic key_back_reset_in,
    input wire logic key_stop_in,
    input wire logic key_up_in,
    input wire logic key_down_in,
    input wire logic reset_digital_input_in,
    input wire logic [15:0] day_in,
    input wire logic [4:0] hour_in,
    input wire logic [5:0] minute_in,
    output logic power_enable_out,
    output logic run_out,
    output logic fault_marker_out,
    output logic fault_flash_out,
    output logic reset_bars_out,
    output logic [7:0] fault_code_out,
    output logic alarm_marker_out,
    output logic [7:0] warning_prefix_code_out,
    output logic show_alarm_out,
    output logic view_marker_flash_out,
    output logic factory_restore_out,
    output logic [3:0] fault_history_menu_sel_out,
    output logic [7:0] log_code_out,
    output logic [15:0] log_day_out,
    output logic [4:0] log_hour_out,
    output logic [5:0] log_minute_out
);
    typedef struct packed {
        dfa_show_t show;
        logic tripped;
        logic sys_fault;
        logic [7:0] code;
        logic ok_armed;
        logic menu_flash;
        logic [31:0] hold_cnt;
        logic [31:0] bars_cnt;
        logic [31:0] blink_cnt;
        logic blink;
        logic restore;
        logic [3:0] sel;
        logic [7:0] alarm_code;
        logic run;
        logic start_q;
    } dfa_state_t;

    dfa_state_t st;
    dfa_state_t next_st;
    logic [7:0] det_code;
    logic ack;
    logic clear;
    logic push;

    // ----------------------------------------
    // Condition classification
    // ----------------------------------------
    function automatic logic [7:0] classify_fault(input logic [15:0] cur,
                                                  input logic [15:0] rated,
                                                  input logic signed [8:0] temp);
        logic [17:0] limit;
        limit = 18'(rated) * 18'(DFA_OVERCURRENT_MULT);
        classify_fault = DFA_CODE_NONE;
        if (system_error_in) classify_fault = DFA_CODE_SYSTEM;
        else if (18'(cur) > limit) classify_fault = DFA_CODE_OVERCURRENT;
        else if (dc_over_limit_in) classify_fault = DFA_CODE_OVERVOLTAGE;
        else if (start_leak_in) classify_fault = DFA_CODE_GROUND;
        else if (dc_under_limit_in) classify_fault = DFA_CODE_UNDERVOLTAGE;
        else if (temp < DFA_TEMP_LOW_C) classify_fault = DFA_CODE_UNDERTEMP;
        else if (temp > DFA_TEMP_TRIP_C) classify_fault = DFA_CODE_OVERTEMP;
    endfunction

    assign det_code = classify_fault(motor_current_in, rated_current_in, switch_temp_in);
    // Reset input acts alone; keypad needs OK first
    assign ack = (st.ok_armed && key_back_reset_in) || reset_digital_input_in;
    // Supply loss also clears system fault, since it models the power cycle
    assign clear = supply_lost_in || (ack && !st.sys_fault);
    assign push = (det_code != DFA_CODE_NONE) && !st.tripped;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.restore = 1'b0;
        next_st.start_q = start_cmd_in;
        if (st.blink_cnt >= 32'(FLASH_CYC - 1)) begin
            next_st.blink_cnt = '0;
            next_st.blink = !st.blink;
        end else begin
            next_st.blink_cnt = st.blink_cnt + 32'd1;
        end
        if (key_ok_in) next_st.ok_armed = 1'b1;
        else if (key_back_reset_in) next_st.ok_armed = 1'b0;

        case (st.show)
            DFA_SHOW_IDLE: begin
                if (push) begin
                    next_st.show = DFA_SHOW_FLASH;
                end
            end
            DFA_SHOW_FLASH: begin
                if (clear) begin
                    next_st.show = DFA_SHOW_BARS;
                    next_st.bars_cnt = '0;
                end
            end
            DFA_SHOW_BARS: begin
                if (push) next_st.show = DFA_SHOW_FLASH;
                else if (st.bars_cnt >= 32'(BARS_CYC - 1)) next_st.show = DFA_SHOW_STEADY;
                else next_st.bars_cnt = st.bars_cnt + 32'd1;
            end
            DFA_SHOW_STEADY: begin
                if (push) next_st.show = DFA_SHOW_FLASH;
                else if (key_back_reset_in) begin
                    next_st.show = DFA_SHOW_IDLE;
                    next_st.menu_flash = 1'b1;
                end
            end
            default: next_st.show = DFA_SHOW_IDLE;
        endcase

        // Push needs tripped low, so ack clears first; a fault still present re-trips next cycle
        if (push) begin
            next_st.tripped = 1'b1;
            next_st.code = det_code;
            next_st.sys_fault = (det_code == DFA_CODE_SYSTEM);
            next_st.sel = 4'h0;
            next_st.menu_flash = 1'b0;
        end else if (st.tripped && clear) begin
            next_st.tripped = 1'b0;
            next_st.sys_fault = 1'b0;
        end

        // Factory restore: marker flashing and stop held
        // A new fault outranks the restore, so its code is never wiped
        if (st.menu_flash && key_stop_in && !push) begin
            if (st.hold_cnt >= 32'(HOLD_CYC - 1)) begin
                next_st.restore = 1'b1;
                next_st.hold_cnt = '0;
                next_st.menu_flash = 1'b0;
                next_st.code = DFA_CODE_NONE;
            end else begin
                next_st.hold_cnt = st.hold_cnt + 32'd1;
            end
        end else begin
            next_st.hold_cnt = '0;
        end

        if (key_up_in && st.sel < 4'(DFA_LOG_DEPTH - 1)) next_st.sel = st.sel + 4'h1;
        else if (key_down_in && st.sel != 4'h0) next_st.sel = st.sel - 4'h1;

        // Alarms share fault codes; they never trip
        if (live_zero_lost_in) next_st.alarm_code = DFA_CODE_LIVE_ZERO;
        else if (switch_temp_in > DFA_TEMP_WARN_C) next_st.alarm_code = DFA_CODE_OVERTEMP;
        else next_st.alarm_code = DFA_CODE_NONE;

        // Run follows start; trips stop it; alarm 50 pauses without latching
        if (push || next_st.tripped) begin
            next_st.run = 1'b0;
        end else if (st.tripped && clear && start_cmd_in
                     && auto_restart_parameter_in == DFA_RESTART_ENABLED) begin
            next_st.run = 1'b1;
        end else if (start_cmd_in && !st.start_q) begin
            next_st.run = 1'b1;
        end else if (!start_cmd_in) begin
            next_st.run = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            st <= '0;
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Fault log
    // ----------------------------------------
    dfa_fault_log #(.DEPTH(DFA_LOG_DEPTH)) u_log (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .push_in(push),
        .erase_in(st.restore),
        .code_in(det_code),
        .day_in(day_in),
        .hour_in(hour_in),
        .minute_in(minute_in),
        .sel_in(st.sel),
        .code_out(log_code_out),
        .day_out(log_day_out),
        .hour_out(log_hour_out),
        .minute_out(log_minute_out)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Alarm-only keeps output; live zero just pauses the run
    assign power_enable_out = !st.tripped;
    assign run_out = st.run && !st.tripped && !live_zero_lost_in;
    assign fault_marker_out = (st.show == DFA_SHOW_FLASH);
    assign fault_flash_out = (st.show == DFA_SHOW_FLASH) && st.blink;
    assign reset_bars_out = (st.show == DFA_SHOW_BARS);
    assign fault_code_out = st.code;
    assign alarm_marker_out = (st.alarm_code != DFA_CODE_NONE);
    assign warning_prefix_code_out = st.alarm_code;
    assign show_alarm_out = alarm_marker_out && st.blink;
    assign view_marker_flash_out = st.menu_flash && st.blink;
    assign factory_restore_out = st.restore;
    assign fault_history_menu_sel_out = st.sel;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    trip_cuts_power_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push |=> !power_enable_out)
        else $error("Fault did not disable power");
    alarm_keeps_power_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !st.tripped && clk_en_in && det_code == DFA_CODE_NONE |=> power_enable_out)
        else $error("Alarm disabled power");
    system_no_ack_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        st.sys_fault && !supply_lost_in |=> st.tripped)
        else $error("System fault cleared by acknowledge");
    ack_shows_bars_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && st.show == DFA_SHOW_FLASH && clear |=> reset_bars_out && !fault_marker_out)
        else $error("Acknowledge did not show bars");
    overcurrent_code_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push && det_code == DFA_CODE_OVERCURRENT |=> fault_code_out == 8'h01)
        else $error("Overcurrent code wrong");
    overtemp_warn_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && !live_zero_lost_in && switch_temp_in > 9'sd110
        |=> warning_prefix_code_out == 8'h0E)
        else $error("Overtemperature warning missing");
    restart_auto_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && st.tripped && clear && !push && start_cmd_in
        && auto_restart_parameter_in == 4'h0 |=> st.run)
        else $error("Auto restart missing");
    restore_erases_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && factory_restore_out && !push ##1 clk_en_in |=> log_code_out == 8'h00)
        else $error("Log not erased");

    // ----------------------------------------
    // Display, log, trip and restart checks
    // ----------------------------------------
    fault_code_latch_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push |=> fault_code_out == $past(det_code))
        else $error("Fault code not latched");
    first_fault_wins_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && st.tripped && !clear && !st.menu_flash |=> fault_code_out == $past(fault_code_out))
        else $error("Fault code changed while tripped");
    flash_until_ack_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && st.show == DFA_SHOW_FLASH && !clear |=> fault_marker_out)
        else $error("Fault marker dropped before acknowledge");
    bars_end_steady_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && reset_bars_out && !push && st.bars_cnt >= 32'(BARS_CYC - 1) |=> st.show == DFA_SHOW_STEADY)
        else $error("Bars did not end in steady display");
    log_push_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push ##1 clk_en_in |=> log_code_out == $past(det_code, 2))
        else $error("Newest log entry wrong");
    sel_range_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        fault_history_menu_sel_out <= 4'(DFA_LOG_DEPTH - 1))
        else $error("Log selection out of range");
    sys_fault_flag_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push && det_code == DFA_CODE_SYSTEM |=> st.sys_fault)
        else $error("System fault not flagged");
    live_zero_code_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && live_zero_lost_in |=> warning_prefix_code_out == DFA_CODE_LIVE_ZERO)
        else $error("Live zero alarm code wrong");
    restore_pulse_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && factory_restore_out |=> !factory_restore_out)
        else $error("Restore pulse too long");
    no_restart_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && st.tripped && clear && !push && st.start_q
        && auto_restart_parameter_in != DFA_RESTART_ENABLED |=> !st.run)
        else $error("Restart without restart setting");
    back_to_view_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && st.show == DFA_SHOW_STEADY && !push && !key_stop_in && key_back_reset_in
        |=> st.menu_flash)
        else $error("Data view marker not flashing");
    supply_clears_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && supply_lost_in && !push |=> power_enable_out)
        else $error("Supply loss did not clear fault");
    overvolt_code_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push && det_code == DFA_CODE_OVERVOLTAGE |=> fault_code_out == 8'h02)
        else $error("Overvoltage code wrong");
    ground_code_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push && det_code == DFA_CODE_GROUND |=> fault_code_out == 8'h03)
        else $error("Ground fault code wrong");
    undervolt_code_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && push && det_code == DFA_CODE_UNDERVOLTAGE |=> fault_code_out == 8'h09)
        else $error("Undervoltage code wrong");
    undertemp_trip_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && !st.tripped && switch_temp_in < DFA_TEMP_LOW_C |=> !power_enable_out)
        else $error("Undertemperature did not trip");
    overtemp_trip_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && !st.tripped && switch_temp_in > DFA_TEMP_TRIP_C |=> !power_enable_out)
        else $error("Overtemperature did not trip");
    run_holds_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        clk_en_in && st.run && !push && start_cmd_in |=> st.run)
        else $error("Run dropped without trip or stop");
endmodule // dfa_manager

// ==== logic/dfa_pkg.sv ====
// Package for the drive fault and alarm manager: codes, timing, display states.
// Assumes a 125 MHz system clock; temperature inputs are signed degrees Celsius.
package dfa_pkg;
    // ----------------------------------------
    // Fault and alarm codes (one shared numbering space)
    // ----------------------------------------
    localparam logic [7:0] DFA_CODE_NONE = 8'h00;
    localparam logic [7:0] DFA_CODE_OVERCURRENT = 8'h01;
    localparam logic [7:0] DFA_CODE_OVERVOLTAGE = 8'h02;
    localparam logic [7:0] DFA_CODE_GROUND = 8'h03;
    localparam logic [7:0] DFA_CODE_SYSTEM = 8'h08;
    localparam logic [7:0] DFA_CODE_UNDERVOLTAGE = 8'h09;
    localparam logic [7:0] DFA_CODE_UNDERTEMP = 8'h0D;
    localparam logic [7:0] DFA_CODE_OVERTEMP = 8'h0E;
    localparam logic [7:0] DFA_CODE_LIVE_ZERO = 8'h32;
    // ----------------------------------------
    // Limits and log shape
    // ----------------------------------------
    localparam int DFA_OVERCURRENT_MULT = 4;
    localparam logic signed [8:0] DFA_TEMP_LOW_C = -9'sd10;
    localparam logic signed [8:0] DFA_TEMP_TRIP_C = 9'sd120;
    localparam logic signed [8:0] DFA_TEMP_WARN_C = 9'sd110;
    localparam int DFA_LOG_DEPTH = 9;
    localparam logic [3:0] DFA_RESTART_ENABLED = 4'h0;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int DFA_CLK_MHZ = 125;
    localparam int DFA_FACTORY_HOLD_MS = 5000;
    localparam int DFA_FACTORY_HOLD_CYC = DFA_FACTORY_HOLD_MS * 1000 * DFA_CLK_MHZ;
    localparam int DFA_BARS_US = 500000;
    localparam int DFA_BARS_CYC = DFA_BARS_US * DFA_CLK_MHZ;
    localparam int DFA_FLASH_US = 250000;
    localparam int DFA_FLASH_CYC = DFA_FLASH_US * DFA_CLK_MHZ;
    // ----------------------------------------
    // Display phase of the current fault
    // ----------------------------------------
    typedef enum logic [1:0] {
        DFA_SHOW_IDLE = 2'b00,
        DFA_SHOW_FLASH = 2'b01,
        DFA_SHOW_BARS = 2'b11,
        DFA_SHOW_STEADY = 2'b10
    } dfa_show_t;
endpackage

// ==== logic/dfa_fault_log.sv ====
// Nine-entry fault log with day/hour/minute stamps, newest at index 0.
// Assumes the owner pulses push_in once per new fault.
`timescale 1ns/1ps
module dfa_fault_log
    import dfa_pkg::*;
#(
    parameter int DEPTH = DFA_LOG_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic push_in,
    input wire logic erase_in,
    input wire logic [7:0] code_in,
    input wire logic [15:0] day_in,
    input wire logic [4:0] hour_in,
    input wire logic [5:0] minute_in,
    input wire logic [3:0] sel_in,
    output logic [7:0] code_out,
    output logic [15:0] day_out,
    output logic [4:0] hour_out,
    output logic [5:0] minute_out
);
    typedef struct packed {
        logic [7:0] code;
        logic [15:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
    } dfa_entry_t;
    typedef struct packed {
        dfa_entry_t [DEPTH-1:0] ent;
        dfa_entry_t rd;
    } dfa_log_st_t;

    dfa_log_st_t st;
    dfa_log_st_t next_st;

    // ----------------------------------------
    // Shift-in storage and read port
    // ----------------------------------------
    always_comb begin
        next_st = st;
        if (erase_in) begin
            next_st.ent = '0;
        end else if (push_in) begin
            // Oldest falls off the end when full
            for (int i = DEPTH - 1; i > 0; i--) begin
                next_st.ent[i] = st.ent[i-1];
            end
            next_st.ent[0] = '{code_in, day_in, hour_in, minute_in};
        end
        if (sel_in < DEPTH[3:0]) begin
            next_st.rd = st.ent[sel_in];
        end else begin
            next_st.rd = '0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            st <= '0;
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    assign code_out = st.rd.code;
    assign day_out = st.rd.day;
    assign hour_out = st.rd.hour;
    assign minute_out = st.rd.minute;
endmodule // dfa_fault_log

// ==== test/dfa_panel_model.sv ====
// Keypad, control terminals and power stage facing the fault manager.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module dfa_panel_model (
    input wire logic sys_clk_in,
    input wire logic power_enable_in,
    output logic key_ok_out,
    output logic key_back_reset_out,
    output logic key_stop_out,
    output logic key_up_out,
    output logic key_down_out,
    output logic reset_digital_input_out,
    output logic start_cmd_out,
    output logic coasting_out
);
    // ----------------------------------------
    // Keys and terminals
    // ----------------------------------------
    logic [5:0] keys = 6'h00;
    assign key_ok_out = keys[0];
    assign key_back_reset_out = keys[1];
    assign key_stop_out = keys[2];
    assign key_up_out = keys[3];
    assign key_down_out = keys[4];
    assign reset_digital_input_out = keys[5];
    initial start_cmd_out = 1'b0;
    // ----------------------------------------
    // Power stage
    // ----------------------------------------
    // No braking model: with gates off the motor can only coast
    always_ff @(posedge sys_clk_in) begin
        coasting_out <= !power_enable_in;
    end
    // Whole cycles only, as a debounced key gives; OK and back/reset never share one
    task automatic press(input int k, input int n);
        @(posedge sys_clk_in);
        keys[k] <= 1'b1;
        repeat (n) @(posedge sys_clk_in);
        keys[k] <= 1'b0;
    endtask
    task automatic set_start(input logic v);
        @(posedge sys_clk_in);
        start_cmd_out <= v;
    endtask
endmodule // dfa_panel_model

// ==== test/tb.sv ====
// Self-checking bench for the drive fault and alarm manager.
// Assumes the panel model drives keys; long counts shortened by parameter.
`timescale 1ns/1ps
module tb
    import dfa_pkg::*;
;
    localparam int BARS = 4;
    logic clk = 1'b0, rst = 1'b1, en = 1'b1;
    logic [15:0] cur = 16'h0000, rated = 16'h000A, day = 16'h00A5;
    logic ovr = 1'b0, und = 1'b0, leak = 1'b0, serr = 1'b0, lz = 1'b0, sup = 1'b0;
    logic signed [8:0] temp = 9'sd25;
    logic [3:0] par = 4'h0;
    logic [4:0] hour = 5'h11;
    logic [5:0] minute = 6'h00;
    logic k_ok, k_back, k_stop, k_up, k_down, rdi, start, coast;
    logic pwr, run, fmark, fflash, bars, amark, shal, vflash, fres;
    logic [7:0] fcode, wcode, lcode;
    logic [3:0] sel;
    logic [15:0] lday;
    logic [4:0] lhour;
    logic [5:0] lmin;
    int miscompares = 0, n_tests = 0, nres = 0, i;

    dfa_manager #(.HOLD_CYC(20), .BARS_CYC(BARS), .FLASH_CYC(2)) dut (
        .sys_clk_in(clk), .reset_in(rst), .clk_en_in(en),
        .motor_current_in(cur), .rated_current_in(rated), .dc_over_limit_in(ovr),
        .dc_under_limit_in(und), .start_leak_in(leak), .system_error_in(serr),
        .switch_temp_in(temp), .live_zero_lost_in(lz), .supply_lost_in(sup),
        .start_cmd_in(start), .auto_restart_parameter_in(par), .key_ok_in(k_ok),
        .key_back_reset_in(k_back), .key_stop_in(k_stop), .key_up_in(k_up),
        .key_down_in(k_down), .reset_digital_input_in(rdi), .day_in(day),
        .hour_in(hour), .minute_in(minute), .power_enable_out(pwr), .run_out(run),
        .fault_marker_out(fmark), .fault_flash_out(fflash), .reset_bars_out(bars),
        .fault_code_out(fcode), .alarm_marker_out(amark),
        .warning_prefix_code_out(wcode), .show_alarm_out(shal),
        .view_marker_flash_out(vflash), .factory_restore_out(fres),
        .fault_history_menu_sel_out(sel), .log_code_out(lcode), .log_day_out(lday),
        .log_hour_out(lhour), .log_minute_out(lmin)
    );
    dfa_panel_model panel (
        .sys_clk_in(clk), .power_enable_in(pwr), .key_ok_out(k_ok),
        .key_back_reset_out(k_back), .key_stop_out(k_stop), .key_up_out(k_up),
        .key_down_out(k_down), .reset_digital_input_out(rdi),
        .start_cmd_out(start), .coasting_out(coast)
    );
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial forever #4 clk = ~clk;
    always @(posedge clk) if (fres === 1'b1) nres <= nres + 1;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] code_of(input int k);
        case (k)
            0: return DFA_CODE_OVERVOLTAGE;
            1: return DFA_CODE_GROUND;
            2: return DFA_CODE_UNDERVOLTAGE;
            3: return DFA_CODE_UNDERTEMP;
            4: return DFA_CODE_OVERTEMP;
            5: return DFA_CODE_SYSTEM;
            default: return DFA_CODE_OVERCURRENT;
        endcase
    endfunction
    // Minute carries the entry number so log order can be told apart
    task automatic cause(input int k, input logic v);
        @(posedge clk) begin
            minute <= 6'(k);
            case (k)
                0: ovr <= v;
                1: leak <= v;
                2: und <= v;
                3: temp <= v ? -9'sd11 : 9'sd25;
                4: temp <= v ? 9'sd121 : 9'sd25;
                5: serr <= v;
                default: cur <= v ? 16'h0029 : 16'h0000;
            endcase
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_alarms();
        logic hi = 1'b0;
        logic lo = 1'b0;
        panel.set_start(1'b1);
        step(2);
        @(posedge clk) temp <= 9'sd120;
        step(2);
        chk(amark, 1'b1);
        chk(wcode, DFA_CODE_OVERTEMP);
        chk(pwr, 1'b1);
        chk(run, 1'b1);
        for (i = 0; i < 12; i++) begin
            step(1);
            if (shal === 1'b1) hi = 1'b1;
            if (shal === 1'b0) lo = 1'b1;
        end
        chk(hi & lo, 1'b1);
        @(posedge clk) temp <= 9'sd110;
        step(2);
        chk(amark, 1'b0);
        @(posedge clk) temp <= -9'sd10;
        step(2);
        chk(pwr, 1'b1);
        @(posedge clk) begin
            temp <= 9'sd25;
            lz <= 1'b1;
        end
        step(2);
        chk(wcode, DFA_CODE_LIVE_ZERO);
        chk(run, 1'b0);
        chk(pwr, 1'b1);
        @(posedge clk) lz <= 1'b0;
        step(2);
        chk(run, 1'b1);
    endtask
    // Ten trips overfill the nine-entry log; restart is switched off meanwhile
    task automatic t_codes();
        @(posedge clk) par <= 4'h1;
        for (int k = 0; k < 10; k++) begin
            cause(k, 1'b1);
            step(1);
            chk(pwr, 1'b0);
            chk(fcode, code_of(k));
            cause(k, 1'b0);
            step(2);
            chk(lcode, code_of(k));
            chk(lmin, 6'(k));
            panel.press(5, 1);
            step(2);
            chk(pwr, (k == 5) ? 1'b0 : 1'b1);
            chk(run, 1'b0);
            @(posedge clk) sup <= 1'b1;
            @(posedge clk) sup <= 1'b0;
            step(BARS + 2);
            chk(pwr, 1'b1);
        end
    endtask
    task automatic t_log();
        for (int k = 0; k < 8; k++) panel.press(3, 1);
        step(2);
        chk(sel, 4'h8);
        chk(lmin, 6'h01);
        chk(lcode, code_of(1));
        chk(lday, 16'h00A5);
        chk(lhour, 5'h11);
        panel.press(4, 1);
        step(2);
        chk(lmin, 6'h02);
        for (int k = 0; k < 7; k++) panel.press(4, 1);
        step(2);
        chk(sel, 4'h0);
        @(posedge clk) en <= 1'b0;
        panel.press(3, 1);
        step(2);
        chk(sel, 4'h0);
        @(posedge clk) en <= 1'b1;
    endtask
    task automatic t_ack_restart();
        logic hi = 1'b0;
        logic lo = 1'b0;
        @(posedge clk) begin
            par <= 4'h0;
            minute <= 6'h2A;
            cur <= 16'h0028;
        end
        step(2);
        chk(pwr, 1'b1);
        @(posedge clk) cur <= 16'h0029;
        step(1);
        chk(pwr, 1'b0);
        chk(fmark, 1'b1);
        step(1);
        chk(coast, 1'b1);
        @(posedge clk) cur <= 16'h0000;
        for (i = 0; i < 12; i++) begin
            step(1);
            if (fflash === 1'b1) hi = 1'b1;
            if (fflash === 1'b0) lo = 1'b1;
        end
        chk(hi & lo, 1'b1);
        panel.press(0, 1);
        step(2);
        chk(fmark, 1'b1);
        panel.press(1, 1);
        step(1);
        chk(bars, 1'b1);
        chk(fmark | fflash, 1'b0);
        chk(run, 1'b1);
        step(BARS + 1);
        chk(bars, 1'b0);
        chk(lcode, DFA_CODE_OVERCURRENT);
        chk(lmin, 6'h2A);
        panel.press(1, 1);
        for (i = 0; i < 16 && vflash !== 1'b1; i++) step(1);
        chk(vflash, 1'b1);
        if (i >= 16) tally_and_finish();
        panel.press(2, 21);
        step(2);
        chk(nres, 1);
        chk(lcode, DFA_CODE_NONE);
    endtask
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(1);
        chk(pwr, 1'b1);
        t_alarms();
        t_codes();
        t_log();
        t_ack_restart();
        tally_and_finish();
    end
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule // tb
